/* File: smc_pkg.sv */
// Purpose: Constants and types for the sleep mode controller
// Assumes: APB word-addressed registers, 25 MHz pclk
// Notes: Shared by the controller and its testbench
package smc_pkg;
	localparam logic [11:0] SMC_CTRL_ADDR = 12'h000;
	localparam logic [11:0] SMC_STAT_ADDR = 12'h004;
	localparam logic [11:0] SMC_CFG_ADDR = 12'h008;
	localparam int SMC_ARM_BIT = 0;
	localparam int SMC_MODE_LSB = 1;
	localparam logic [3:0] SMC_CTRL_MASK = 4'hF;
	localparam logic [3:0] SMC_CTRL_RESET = 4'h0;
	localparam logic [7:0] SMC_CFG_RESET = 8'h10;
	localparam logic [2:0] SMC_MODE_IDLE = 3'h0;
	localparam logic [2:0] SMC_MODE_NOISE = 3'h1;
	localparam logic [2:0] SMC_MODE_PDOWN = 3'h2;
	localparam logic [2:0] SMC_MODE_PSAVE = 3'h3;
	localparam logic [2:0] SMC_MODE_STBY = 3'h6;
	localparam logic [2:0] SMC_MODE_XSTBY = 3'h7;
	localparam logic [7:0] SMC_HALT_CYCLES = 8'h04;
	localparam logic [7:0] SMC_STBY_WAKE_CYCLES = 8'h06;
	// Wake source bit positions
	localparam int SMC_WK_LOWLVL = 0;
	localparam int SMC_WK_LOWEDGE = 1;
	localparam int SMC_WK_HIGHLVL = 2;
	localparam int SMC_WK_PINCHG = 3;
	localparam int SMC_WK_TWIADDR = 4;
	localparam int SMC_WK_WDT = 5;
	localparam int SMC_WK_TIMER2 = 6;
	localparam int SMC_WK_SPMEE = 7;
	localparam int SMC_WK_ADC = 8;
	localparam int SMC_WK_OTHER = 9;
	localparam int SMC_WK_N = 10;
	localparam logic [9:0] SMC_WK_IDLE = 10'h3FF;
	localparam logic [9:0] SMC_WK_NOISE = 10'h1FD;
	localparam logic [9:0] SMC_WK_PDOWN = 10'h03D;
	localparam logic [9:0] SMC_WK_PSAVE = 10'h07D;
	typedef enum logic [4:0] {
		SMC_RUN = 5'h01,
		SMC_SLEEP = 5'h02,
		SMC_RESTART = 5'h04,
		SMC_HALT = 5'h08,
		SMC_RESUME = 5'h10
	} smc_state_e;
endpackage : smc_pkg

/* File: smc_sleep_ctrl.sv */
// Purpose: Sleep mode controller: clock gating and wake-up sequencing
// Assumes: Core pulses sleep_instr; interrupt system gives wake lines
// Notes: Register file and SRAM are never cleared by this block
//
// Summary of operation
// - Sleep only when arm bit set at SLEEP
// - Mode field decodes six modes, two reserved
// - Interrupt wake holds core four extra cycles
// - Register file and SRAM kept across sleep
// - Reset during sleep restarts at reset vector
// - Idle stops only core and flash clocks
// - Converter enabled starts conversion in idle/noise
// - Noise mode stops I/O, core, flash clocks
// - Noise mode wake sources restricted
// - Power-down stops oscillator and generated clocks
// - Power-down wake sources restricted
// - Power-down wake delayed by restart period
// - Power-save adds enabled async timer wake
// - Power-save timer oscillator or main clock stopped
// - Code 110 with crystal is standby
// - Code 111 with crystal is extended standby
// - Deep modes wake low lines on level only
// - Idle wakes on any enabled interrupt
//
// Chosen here: the placing of the registers and the APB register port.
`timescale 1ns/1ps
module smc_sleep_ctrl
	import smc_pkg::*;
#(
	parameter logic [15:0] RESTART_CYCLES = 16'h0010
) (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic [3:0] pstrb,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic sleep_instr,
	input wire logic any_reset,
	input wire logic [9:0] wake_req,
	input wire logic converter_enabled,
	input wire logic timer_async_clocked,
	input wire logic timer_running,
	input wire logic timer_irq_ok,
	input wire logic crystal_selected,
	output logic core_clock_en,
	output logic program_memory_clock_en,
	output logic peripheral_clock_en,
	output logic converter_clock_en,
	output logic async_timer_clock_en,
	output logic main_osc_en,
	output logic timer_osc_en,
	output logic core_hold,
	output logic resume_after_sleep,
	output logic restart_from_vector,
	output logic start_conversion,
	output logic sleeping
);

	////////////////////////////////////////////////////////////////////
	typedef struct packed {
		smc_state_e state;
		logic [3:0] ctrl;
		logic [7:0] cfg;
		logic [2:0] mode;
		logic [15:0] count;
		logic from_irq;
		logic vector;
		logic resume;
		logic conv;
		logic [31:0] rdata;
	} smc_regs_s;

	smc_regs_s r_q;
	smc_regs_s r_d;

	logic wr_en;
	logic rd_en;
	logic addr_ok;
	logic [2:0] mode_sel;
	logic mode_valid;
	logic [9:0] wk_mask;
	logic [9:0] wk_hit;
	logic wake;
	logic deep;

	assign addr_ok = (paddr == SMC_CTRL_ADDR) || (paddr == SMC_STAT_ADDR)
		|| (paddr == SMC_CFG_ADDR);
	assign wr_en = psel && penable && pwrite && addr_ok;
	assign rd_en = psel && !penable && !pwrite;
	assign pready = 1'b1;
	assign pslverr = psel && penable && !addr_ok;
	assign prdata = r_q.rdata;

	// Standby codes fall back to reserved without a crystal
	assign mode_sel = r_q.ctrl[SMC_MODE_LSB +: 3];
	always_comb begin
		// Reserved codes leave mode_valid low, so SLEEP does nothing
		case (mode_sel)
			SMC_MODE_IDLE: mode_valid = 1'b1;
			SMC_MODE_NOISE: mode_valid = 1'b1;
			SMC_MODE_PDOWN: mode_valid = 1'b1;
			SMC_MODE_PSAVE: mode_valid = 1'b1;
			SMC_MODE_STBY: mode_valid = crystal_selected;
			SMC_MODE_XSTBY: mode_valid = crystal_selected;
			default: mode_valid = 1'b0;
		endcase
	end

	assign deep = (r_q.mode != SMC_MODE_IDLE);

	////////////////////////////////////////////////////////////////////
	// Wake source filter for the mode held during sleep
	always_comb begin
		case (r_q.mode)
			SMC_MODE_IDLE: wk_mask = SMC_WK_IDLE;
			SMC_MODE_NOISE: wk_mask = SMC_WK_NOISE;
			SMC_MODE_PDOWN: wk_mask = SMC_WK_PDOWN;
			SMC_MODE_PSAVE: wk_mask = SMC_WK_PSAVE;
			SMC_MODE_STBY: wk_mask = SMC_WK_PDOWN;
			SMC_MODE_XSTBY: wk_mask = SMC_WK_PSAVE;
			default: wk_mask = SMC_WK_PDOWN;
		endcase
	end

	// Edge capture needs the I/O clock, which deep modes stop;
	// so only level requests can be trusted there
	genvar gi;
	generate
		for (gi = 0; gi < SMC_WK_N; gi++) begin : g_wk
			if (gi == SMC_WK_TIMER2) begin : g_t2
				// In deep modes timer wake needs the timer alive and its irq enabled
				assign wk_hit[gi] = wake_req[gi] && wk_mask[gi]
					&& (!deep || (timer_running && timer_irq_ok));
			end else if (gi == SMC_WK_LOWEDGE) begin : g_edge
				assign wk_hit[gi] = wake_req[gi] && wk_mask[gi] && !deep;
			end else begin : g_plain
				assign wk_hit[gi] = wake_req[gi] && wk_mask[gi];
			end
		end
	endgenerate

	assign wake = |wk_hit;

	// Oscillator must settle before clocks return
	logic [15:0] restart_len;
	always_comb begin
		case (r_q.mode)
			SMC_MODE_PDOWN: begin
				restart_len = (RESTART_CYCLES > {8'h00, r_q.cfg}) ?
					RESTART_CYCLES : {8'h00, r_q.cfg};
			end
			SMC_MODE_PSAVE: begin
				restart_len = (RESTART_CYCLES > {8'h00, r_q.cfg}) ?
					RESTART_CYCLES : {8'h00, r_q.cfg};
			end
			SMC_MODE_STBY: restart_len = {8'h00, SMC_STBY_WAKE_CYCLES};
			SMC_MODE_XSTBY: restart_len = {8'h00, SMC_STBY_WAKE_CYCLES};
			default: restart_len = 16'h0001;
		endcase
	end

	// Sleep is taken only on an armed, decodable request
	logic sleep_take;
	assign sleep_take = sleep_instr && r_q.ctrl[SMC_ARM_BIT] && mode_valid;

	////////////////////////////////////////////////////////////////////
	always_comb begin
		r_d = r_q;
		r_d.conv = 1'b0;
		r_d.resume = 1'b0;
		r_d.vector = 1'b0;
		if (rd_en) begin
			case (paddr)
				SMC_CTRL_ADDR: r_d.rdata = {28'h0000000, r_q.ctrl};
				SMC_STAT_ADDR: r_d.rdata = {24'h000000, 3'h0, r_q.state};
				SMC_CFG_ADDR: r_d.rdata = {24'h000000, r_q.cfg};
				default: r_d.rdata = 32'h00000000;
			endcase
		end
		if (wr_en && pstrb[0]) begin
			if (paddr == SMC_CTRL_ADDR) begin
				r_d.ctrl = pwdata[3:0] & SMC_CTRL_MASK;
			end else if (paddr == SMC_CFG_ADDR) begin
				r_d.cfg = pwdata[7:0];
			end
		end
		case (r_q.state)
			SMC_RUN: begin
				// Unarmed or reserved code: instruction acts as no-op
				if (sleep_take) begin
					r_d.state = SMC_SLEEP;
					r_d.mode = mode_sel;
					r_d.conv = converter_enabled
						&& (mode_sel == SMC_MODE_IDLE
						|| mode_sel == SMC_MODE_NOISE);
				end
			end
			SMC_SLEEP: begin
				if (wake) begin
					r_d.from_irq = 1'b1;
					r_d.state = SMC_RESTART;
					r_d.count = restart_len;
				end
			end
			SMC_RESTART: begin
				if (r_q.count <= 16'h0001) begin
					r_d.state = SMC_HALT;
					r_d.count = {8'h00, SMC_HALT_CYCLES};
				end else begin
					r_d.count = r_q.count - 16'h0001;
				end
			end
			SMC_HALT: begin
				if (r_q.count <= 16'h0001) begin
					r_d.state = SMC_RESUME;
				end else begin
					r_d.count = r_q.count - 16'h0001;
				end
			end
			SMC_RESUME: begin
				r_d.resume = 1'b1;
				r_d.from_irq = 1'b0;
				r_d.state = SMC_RUN;
			end
			default: r_d.state = SMC_RUN;
		endcase
		// Reset while asleep goes to vector, not past SLEEP
		if (any_reset) begin
			r_d.vector = (r_q.state != SMC_RUN);
			r_d.state = SMC_RUN;
			r_d.from_irq = 1'b0;
			r_d.resume = 1'b0;
			r_d.count = 16'h0000;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			r_q.state <= SMC_RUN;
			r_q.ctrl <= SMC_CTRL_RESET;
			r_q.cfg <= SMC_CFG_RESET;
			r_q.mode <= SMC_MODE_IDLE;
			r_q.count <= 16'h0000;
			r_q.from_irq <= 1'b0;
			r_q.vector <= 1'b0;
			r_q.resume <= 1'b0;
			r_q.conv <= 1'b0;
			r_q.rdata <= 32'h00000000;
		end else begin
			r_q <= r_d;
		end
	end

	////////////////////////////////////////////////////////////////////
	// Clock gates per mode; no memory is touched here
	logic asleep;
	logic g_core;
	logic g_flash;
	logic g_io;
	logic g_conv;
	logic g_async;
	logic g_main;
	logic g_tosc;
	assign asleep = (r_q.state == SMC_SLEEP) || (r_q.state == SMC_RESTART);
	always_comb begin
		g_core = 1'b1;
		g_flash = 1'b1;
		g_io = 1'b1;
		g_conv = 1'b1;
		g_async = 1'b1;
		g_main = 1'b1;
		g_tosc = 1'b1;
		if (asleep) begin
			case (r_q.mode)
				SMC_MODE_IDLE: begin
					g_core = 1'b0;
					g_flash = 1'b0;
					g_io = 1'b1;
					g_conv = 1'b1;
					g_async = 1'b1;
					g_main = 1'b1;
					g_tosc = 1'b1;
				end
				SMC_MODE_NOISE: begin
					g_core = 1'b0;
					g_flash = 1'b0;
					g_io = 1'b0;
					g_conv = 1'b1;
					g_async = 1'b1;
					g_main = 1'b1;
					g_tosc = 1'b1;
				end
				SMC_MODE_PSAVE: begin
					g_core = 1'b0;
					g_flash = 1'b0;
					g_io = 1'b0;
					g_conv = 1'b0;
					g_async = 1'b1;
					g_main = !timer_async_clocked;
					g_tosc = timer_async_clocked;
				end
				SMC_MODE_STBY: begin
					g_core = 1'b0;
					g_flash = 1'b0;
					g_io = 1'b0;
					g_conv = 1'b0;
					g_async = 1'b0;
					g_main = 1'b1;
					g_tosc = 1'b0;
				end
				SMC_MODE_XSTBY: begin
					g_core = 1'b0;
					g_flash = 1'b0;
					g_io = 1'b0;
					g_conv = 1'b0;
					g_async = timer_async_clocked;
					g_main = 1'b1;
					g_tosc = timer_async_clocked;
				end
				default: begin
					g_core = 1'b0;
					g_flash = 1'b0;
					g_io = 1'b0;
					g_conv = 1'b0;
					g_async = 1'b0;
					g_main = 1'b0;
					g_tosc = 1'b0;
				end
			endcase
			// Oscillator restarts first so clocks come back stable
			if (r_q.state == SMC_RESTART && r_q.mode != SMC_MODE_IDLE) begin
				g_main = 1'b1;
			end
		end
		// Core and flash stay off through the halt cycles
		if (r_q.state == SMC_HALT) begin
			g_core = 1'b0;
			g_flash = 1'b0;
			g_io = 1'b1;
			g_conv = 1'b1;
			g_async = 1'b1;
			g_main = 1'b1;
			g_tosc = 1'b1;
		end
	end
	assign core_clock_en = g_core;
	assign program_memory_clock_en = g_flash;
	assign peripheral_clock_en = g_io;
	assign converter_clock_en = g_conv;
	assign async_timer_clock_en = g_async;
	assign main_osc_en = g_main;
	assign timer_osc_en = g_tosc;
	assign core_hold = (r_q.state != SMC_RUN);
	assign sleeping = (r_q.state == SMC_SLEEP);
	assign resume_after_sleep = r_q.resume;
	assign restart_from_vector = r_q.vector;
	assign start_conversion = r_q.conv;

endmodule : smc_sleep_ctrl

/* File: smc_sleep_ctrl_asserts.sv */
// Purpose: Port-level checks of the sleep mode controller
// Assumes: Single pclk domain, presetn async active low
// Notes: Bound into every controller instance
`timescale 1ns/1ps
module smc_sleep_ctrl_chk (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic any_reset,
	input wire logic [9:0] wake_req,
	input wire logic converter_enabled,
	input wire logic core_clock_en,
	input wire logic program_memory_clock_en,
	input wire logic peripheral_clock_en,
	input wire logic converter_clock_en,
	input wire logic main_osc_en,
	input wire logic core_hold,
	input wire logic resume_after_sleep,
	input wire logic restart_from_vector,
	input wire logic start_conversion,
	input wire logic sleeping
);
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);
	a_sleep_core_off: assert property (sleeping |-> !core_clock_en &&
		!program_memory_clock_en) else $error("core clock on in sleep");
	a_idle_keeps_clocks: assert property (sleeping && peripheral_clock_en
		|-> converter_clock_en && main_osc_en) else $error("idle clock off");
	a_pdown_all_off: assert property (sleeping && !main_osc_en |->
		!peripheral_clock_en && !converter_clock_en) else $error("clock on");
	a_run_clocks_on: assert property (!core_hold |-> core_clock_en &&
		peripheral_clock_en && main_osc_en) else $error("clock off in run");
	a_reset_vector: assert property (any_reset && core_hold |=>
		restart_from_vector) else $error("no restart pulse");
	a_reset_no_resume: assert property (restart_from_vector |->
		!resume_after_sleep) else $error("resume with restart");
	a_edge_ignored: assert property (sleeping && !peripheral_clock_en &&
		wake_req == 10'h002 && !any_reset |=> sleeping) else $error("edge woke");
	a_no_wake_stay: assert property (sleeping && wake_req == 10'h000 &&
		!any_reset |=> sleeping) else $error("woke without cause");
	a_conv_start: assert property (start_conversion |-> converter_enabled
		&& converter_clock_en) else $error("stray conversion start");
	a_halt_span: assert property (resume_after_sleep |-> $past(core_hold) &&
		!$past(sleeping) && !$past(sleeping, 6)) else $error("halt too short");
	c_resume: cover property (resume_after_sleep);
	c_restart: cover property (restart_from_vector);
	c_conv: cover property (start_conversion);
endmodule : smc_sleep_ctrl_chk
bind smc_sleep_ctrl smc_sleep_ctrl_chk chk_u (.*);

/* File: smc_core_model.sv */
// Purpose: Core-side model: issues SLEEP and holds wake levels
// Assumes: Testbench pulses go one cycle after arming
// Notes: Wake level is released only once the core runs again
`timescale 1ns/1ps
module smc_core_model (
	input wire logic pclk,
	input wire logic go,
	input wire logic [9:0] wl,
	input wire logic core_hold,
	output logic sleep_instr,
	output logic [9:0] wake_req
);
	initial sleep_instr = 1'h0;
	initial wake_req = 10'h000;
	always @(posedge pclk) begin
		sleep_instr <= go;
		// Level held until recognised, not just one cycle
		wake_req <= core_hold ? wl : 10'h000;
	end
endmodule : smc_core_model

/* File: testbench.sv */
// Purpose: Self-checking bench for the sleep mode controller
// Assumes: Zero-wait APB, RESTART_CYCLES shortened to 2
// Notes: Wake count is restart + 4 halt + 1 resume cycles
`timescale 1ns/1ps
module testbench import smc_pkg::*;;
	logic pclk, presetn, psel, penable, pwrite, pready, pslverr, er;
	logic [11:0] paddr;
	logic [31:0] pwdata, prdata, rd;
	logic [3:0] pstrb;
	logic sleep_instr, any_reset, converter_enabled, timer_async_clocked;
	logic timer_running, timer_irq_ok, crystal_selected, go;
	logic [9:0] wake_req, wl;
	logic core_clock_en, program_memory_clock_en, peripheral_clock_en;
	logic converter_clock_en, async_timer_clock_en, main_osc_en;
	logic timer_osc_en, core_hold, resume_after_sleep, restart_from_vector;
	logic start_conversion, sleeping, sc_seen, rv_seen, rs_seen;
	int n_fail, comparisons;
	`define CHK(a, b) begin comparisons++; if ((a) !== (b)) begin \
		n_fail++; $display("unexpected %0t bad value", $time); end end
	smc_sleep_ctrl #(.RESTART_CYCLES(16'h0002)) dut_u (.*);
	smc_core_model core_u (.*);
	initial begin
		pclk = 1'h0;
		forever #20 pclk = ~pclk;
	end
	always @(posedge pclk) begin
		if (start_conversion === 1'h1) sc_seen <= 1'h1;
		if (restart_from_vector === 1'h1) rv_seen <= 1'h1;
		if (resume_after_sleep === 1'h1) rs_seen <= 1'h1;
	end
	task automatic apb(input logic w, input logic [11:0] a,
		input logic [31:0] d);
		int t = 0;
		@(posedge pclk);
		psel <= 1'h1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'h1;
		do begin
			@(posedge pclk);
			t++;
		end while (pready !== 1'h1 && t < 20);
		`CHK(pready, 1'h1)
		rd = prdata;
		er = pslverr;
		psel <= 1'h0;
		penable <= 1'h0;
	endtask : apb
	task automatic kick;
		@(posedge pclk);
		go <= 1'h1;
		@(posedge pclk);
		go <= 1'h0;
		repeat (2) @(posedge pclk);
		#1;
	endtask : kick
	task automatic nap(input logic [2:0] m);
		apb(1'h1, SMC_CTRL_ADDR, {28'h0, m, 1'h1});
		kick();
	endtask : nap
	task automatic wake(input logic [9:0] wk, input int exp);
		int n = 0;
		@(posedge pclk);
		wl <= wk;
		for (int i = 0; i < 60; i++) begin
			@(posedge pclk);
			#1;
			if (core_hold === 1'h1 && sleeping !== 1'h1) n++;
			if (core_hold === 1'h0) break;
		end
		`CHK(n, exp)
		`CHK(core_hold, exp == 0)
		@(posedge pclk);
		wl <= 10'h000;
	endtask : wake
	task automatic t_regs;
		apb(1'h0, SMC_CFG_ADDR, 32'h0);
		`CHK(rd, {24'h0, SMC_CFG_RESET})
		apb(1'h1, SMC_CFG_ADDR, 32'h3);
		apb(1'h0, SMC_CFG_ADDR, 32'h0);
		`CHK(rd, 32'h3)
		apb(1'h1, SMC_CTRL_ADDR, 32'hFE);
		apb(1'h0, SMC_CTRL_ADDR, 32'h0);
		`CHK(rd, 32'hE)
		apb(1'h0, SMC_STAT_ADDR, 32'h0);
		`CHK(rd, 32'h1)
		apb(1'h0, 12'h00C, 32'h0);
		`CHK(er, 1'h1)
		`CHK(rd, 32'h0)
	endtask : t_regs
	task automatic t_noop;
		logic [31:0] v[4] = '{32'h0, 32'h9, 32'hB, 32'hD};
		foreach (v[i]) begin
			apb(1'h1, SMC_CTRL_ADDR, v[i]);
			kick();
			`CHK(core_hold, 1'h0)
			`CHK(core_clock_en, 1'h1)
		end
	endtask : t_noop
	task automatic t_modes;
		nap(SMC_MODE_IDLE);
		`CHK(core_clock_en, 1'h0)
		`CHK(program_memory_clock_en, 1'h0)
		`CHK(peripheral_clock_en, 1'h1)
		wake(10'h200, 6);
		`CHK(sc_seen, 1'h1)
		nap(SMC_MODE_NOISE);
		`CHK(peripheral_clock_en, 1'h0)
		`CHK(converter_clock_en, 1'h1)
		wake(10'h002, 0);
		wake(10'h100, 6);
		nap(SMC_MODE_PDOWN);
		`CHK(main_osc_en, 1'h0)
		wake(10'h300, 0);
		wake(10'h001, 8);
		nap(SMC_MODE_PSAVE);
		`CHK(async_timer_clock_en, 1'h1)
		`CHK(main_osc_en, 1'h0)
		`CHK(timer_osc_en, 1'h1)
		wake(10'h040, 8);
	endtask : t_modes
	task automatic t_stby;
		@(posedge pclk);
		crystal_selected <= 1'h1;
		nap(SMC_MODE_STBY);
		`CHK(main_osc_en, 1'h1)
		wake(10'h008, 11);
		nap(SMC_MODE_XSTBY);
		`CHK(main_osc_en, 1'h1)
		wake(10'h010, 11);
	endtask : t_stby
	task automatic t_rst;
		nap(SMC_MODE_PDOWN);
		@(posedge pclk);
		rv_seen <= 1'h0;
		rs_seen <= 1'h0;
		any_reset <= 1'h1;
		@(posedge pclk);
		any_reset <= 1'h0;
		repeat (3) @(posedge pclk);
		#1;
		`CHK(rv_seen, 1'h1)
		`CHK(rs_seen, 1'h0)
		`CHK(core_hold, 1'h0)
	endtask : t_rst
	task automatic end_sim;
		$display("comparisons %0d n_fail %0d", comparisons, n_fail);
		if (n_fail == 0 && comparisons > 0) $display("NO MISMATCHES");
		else $display("MISMATCHES SEEN");
		$finish;
	endtask : end_sim
	initial begin
		{presetn, psel, penable, pwrite, any_reset, go} = 6'h00;
		{paddr, pwdata, wl} = 54'h0;
		pstrb = 4'h1;
		{converter_enabled, timer_async_clocked} = 2'h3;
		{timer_running, timer_irq_ok, crystal_selected} = 3'h6;
		{sc_seen, rv_seen, rs_seen} = 3'h0;
		n_fail = 0;
		comparisons = 0;
		repeat (8) @(posedge pclk);
		presetn <= 1'h1;
		t_regs();
		t_noop();
		t_modes();
		t_stby();
		t_rst();
		end_sim();
	end
	initial begin
		#200000;
		n_fail++;
		end_sim();
	end
endmodule : testbench
